// ---- shared/pcvu_pkg.sv ----
/*
 * package of the pushed compare/verify unit: register offsets, field
 * layouts, the unmapped read value, mode encodings and sequencer states.
 * assumes one clock (mclk) and a synchronous active-high reset.
 */
package pcvu_pkg;

	// ==========================================================
	// register map (byte addresses, one word each)
	localparam logic [3:0] PCVU_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] PCVU_ADDR_ABORT  = 4'h4;
	localparam logic [3:0] PCVU_ADDR_STAT   = 4'h8;
	localparam logic [3:0] PCVU_ADDR_IRQST  = 4'hc;
	localparam logic [3:0] PCVU_ADDR_IRQCLR = 4'h0; // upper bank
	localparam logic [3:0] PCVU_ADDR_IRQEN  = 4'h4; // upper bank
	localparam int         PCVU_ADDR_W      = 5;
	localparam int         PCVU_BANK_BIT    = 4;

	// ==========================================================
	// control register fields
	localparam int PCVU_MODE_LO  = 0;
	localparam int PCVU_MASK_LO  = 8;
	localparam int PCVU_CNT_LO   = 12;
	localparam int PCVU_CNT_W    = 12;
	// abort register bit that clears the compare flag
	localparam int PCVU_CLR_BIT  = 1;
	// status register fields
	localparam int PCVU_ST_FLAG  = 0;
	localparam int PCVU_ST_BUSY  = 1;
	localparam int PCVU_ST_CNT   = 4;

	// interrupt events
	localparam int PCVU_EV_W     = 2;
	localparam int PCVU_EV_FLAG  = 0;
	localparam int PCVU_EV_DONE  = 1;

	localparam logic [31:0] PCVU_RD_UNMAPPED = 32'h0000_0000;

	// ==========================================================
	// transfer modes
	typedef enum logic [1:0] {
		PCVU_MODE_NORMAL  = 2'h0,
		PCVU_MODE_VERIFY  = 2'h1,
		PCVU_MODE_COMPARE = 2'h2,
		PCVU_MODE_RSVD    = 2'h3
	} pcvu_mode_t;

	// sequencer states, gray along idle -> issue -> wait -> check
	typedef enum logic [1:0] {
		PCVU_ST_IDLE  = 2'b00,
		PCVU_ST_ISSUE = 2'b01,
		PCVU_ST_WAIT  = 2'b11,
		PCVU_ST_CHECK = 2'b10
	} pcvu_state_t;

endpackage

// ---- hw/pcvu_hold_reg.sv ----
/*
 * holding register for the pushed write value; the lane mask is not held here.
 * assumes load is only pulsed while no comparison is pending.
 */
`timescale 1ns/1ps
`default_nettype none
module pcvu_hold_reg
	import pcvu_pkg::*;
#(
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// load side
	input  wire logic              load,
	input  wire logic [DATA_W-1:0] loadData,
	// held value
	output logic      [DATA_W-1:0] heldData
);

	always_ff @(posedge mclk) begin
		if (srst) begin
			heldData <= '0;
		end else if (load) begin
			heldData <= loadData;
		end
	end

endmodule
`default_nettype wire

// ---- hw/pcvu_lane_cmp.sv ----
/*
 * masked byte-lane equality compare, registered result.
 * assumes inputs stay stable on the cycle that strobe is high.
 */
`timescale 1ns/1ps
`default_nettype none
module pcvu_lane_cmp
	import pcvu_pkg::*;
#(
	parameter int LANES = 4
) (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               srst,
	// operands
	input  wire logic               strobe,
	input  wire logic [LANES*8-1:0] a,
	input  wire logic [LANES*8-1:0] b,
	input  wire logic [LANES-1:0]   laneMask,
	// result, valid the cycle after strobe
	output logic                    equal,
	output logic                    valid
);

	function automatic logic lanesMatch(
		input logic [LANES*8-1:0] x,
		input logic [LANES*8-1:0] y,
		input logic [LANES-1:0]   m
	);
		logic ok;
		ok = 1'b1;
		for (int n = 0; n < LANES; n++) begin
			if (m[n] && (x[n*8 +: 8] != y[n*8 +: 8])) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	always_ff @(posedge mclk) begin
		if (srst) begin
			equal <= 1'b0;
			valid <= 1'b0;
		end else begin
			valid <= strobe;
			if (strobe) begin
				equal <= lanesMatch(a, b, laneMask);
			end
		end
	end

endmodule
`default_nettype wire

// ---- hw/pcvu_core.sv ----
/*
 * pushed compare/verify unit of the debug port: takes port write and read
 * transactions from the link side, turns pushed writes into port reads,
 * compares under a lane mask, keeps the sticky compare flag and repeats.
 * assumes the access port answers each request with one rsp pulse; an
 * unsupported target may answer with any data, leaving the flag arbitrary.
 */
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcvu_core
	import pcvu_pkg::*;
#(
	parameter int LANES = 4,
	parameter int CNT_W = PCVU_CNT_W
) (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               srst,
	// avalon-mm slave
	input  wire logic [PCVU_ADDR_W-1:0] avsAddress,
	input  wire logic               avsRead,
	input  wire logic               avsWrite,
	input  wire logic [31:0]        avsWriteData,
	output logic      [31:0]        avsReadData,
	output logic                    avsWaitRequest,
	// link-side transactions
	input  wire logic               txnValid,
	input  wire logic               txnWrite,
	input  wire logic [LANES*8-1:0] txnData,
	output logic                    txnDone,
	output logic      [LANES*8-1:0] txnRdata,
	// access port side
	output logic                    apReq,
	output logic                    apWrite,
	output logic      [LANES*8-1:0] apWdata,
	input  wire logic               apRsp,
	input  wire logic [LANES*8-1:0] apRdata,
	// interrupt
	output logic                    irq
);

	localparam int DATA_W = LANES * 8;

	// ==========================================================
	// control and state
	pcvu_mode_t           transfer_mode_field;
	logic [LANES-1:0]     byte_lane_mask;
	logic [CNT_W-1:0]     repeat_counter;
	logic                 compare_sticky_flag;
	logic [PCVU_EV_W-1:0] irqStatus;
	logic [PCVU_EV_W-1:0] irqEnable;
	pcvu_state_t          state;
	logic                 pushed;
	logic                 curWrite;
	logic [DATA_W-1:0]    curData;
	logic [DATA_W-1:0]    heldData;
	logic                 cmpEqual;
	logic                 cmpValid;
	logic                 setFlag;
	logic                 seqDone;
	logic                 ctrlWr;
	logic                 flagClr;
	logic                 irqClrWr;
	logic                 irqEnWr;
	logic                 wrPend;
	logic                 rdPend;

	function automatic logic isPushed(input pcvu_mode_t m);
		return (m == PCVU_MODE_VERIFY) || (m == PCVU_MODE_COMPARE);
	endfunction

	// ==========================================================
	// bus slave: one wait state, unmapped reads give zero
	// a write lands only at the edge that sees waitrequest low, as the
	// master completes its transfer there and not a cycle earlier
	assign wrPend = avsWrite && !avsWaitRequest;
	assign rdPend = avsRead && avsWaitRequest;
	assign ctrlWr = wrPend && !avsAddress[PCVU_BANK_BIT]
		&& (avsAddress[3:0] == PCVU_ADDR_CTRL);
	assign flagClr = wrPend && !avsAddress[PCVU_BANK_BIT]
		&& (avsAddress[3:0] == PCVU_ADDR_ABORT)
		&& avsWriteData[PCVU_CLR_BIT];
	assign irqClrWr = wrPend && avsAddress[PCVU_BANK_BIT]
		&& (avsAddress[3:0] == PCVU_ADDR_IRQCLR);
	assign irqEnWr = wrPend && avsAddress[PCVU_BANK_BIT]
		&& (avsAddress[3:0] == PCVU_ADDR_IRQEN);

	always_ff @(posedge mclk) begin
		if (srst) begin
			avsWaitRequest <= 1'b1;
		end else if ((avsRead || avsWrite) && avsWaitRequest) begin
			avsWaitRequest <= 1'b0;
		end else begin
			avsWaitRequest <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			avsReadData <= '0;
		end else if (rdPend) begin
			avsReadData <= PCVU_RD_UNMAPPED;
			if (!avsAddress[PCVU_BANK_BIT]) begin
				case (avsAddress[3:0])
				PCVU_ADDR_CTRL: begin
					avsReadData[PCVU_MODE_LO +: 2] <= transfer_mode_field;
					avsReadData[PCVU_MASK_LO +: LANES] <= byte_lane_mask;
					avsReadData[PCVU_CNT_LO +: CNT_W] <= repeat_counter;
				end
				PCVU_ADDR_STAT: begin
					avsReadData[PCVU_ST_FLAG] <= compare_sticky_flag;
					avsReadData[PCVU_ST_BUSY] <= (state != PCVU_ST_IDLE);
					avsReadData[PCVU_ST_CNT +: CNT_W] <= repeat_counter;
				end
				PCVU_ADDR_IRQST: begin
					avsReadData[PCVU_EV_W-1:0] <= irqStatus;
				end
				default: begin
					avsReadData <= PCVU_RD_UNMAPPED;
				end
				endcase
			end else if (avsAddress[3:0] == PCVU_ADDR_IRQEN) begin
				avsReadData[PCVU_EV_W-1:0] <= irqEnable;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			transfer_mode_field <= PCVU_MODE_NORMAL;
			byte_lane_mask      <= '1;
		end else if (ctrlWr) begin
			transfer_mode_field <=
				pcvu_mode_t'(avsWriteData[PCVU_MODE_LO +: 2]);
			byte_lane_mask <= avsWriteData[PCVU_MASK_LO +: LANES];
		end
	end

	// ==========================================================
	// transaction sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			state    <= PCVU_ST_IDLE;
			pushed   <= 1'b0;
			curWrite <= 1'b0;
			curData  <= '0;
		end else begin
			case (state)
			PCVU_ST_IDLE: begin
				if (txnValid) begin
					pushed   <= isPushed(transfer_mode_field);
					curWrite <= txnWrite;
					curData  <= txnData;
					state    <= PCVU_ST_ISSUE;
				end
			end
			PCVU_ST_ISSUE: begin
				state <= PCVU_ST_WAIT;
			end
			PCVU_ST_WAIT: begin
				if (apRsp) begin
					state <= (pushed && curWrite) ? PCVU_ST_CHECK
						: PCVU_ST_IDLE;
					if (!(pushed && curWrite) && !flagClr
						&& (repeat_counter != '0)
						&& !compare_sticky_flag) begin
						state <= PCVU_ST_ISSUE;
					end
				end
			end
			PCVU_ST_CHECK: begin
				// wait one cycle for the registered comparator result
				if (cmpValid) begin
					state <= (repeat_counter != '0) && !setFlag
						&& !compare_sticky_flag
						? PCVU_ST_ISSUE : PCVU_ST_IDLE;
				end
			end
			default: begin
				state <= PCVU_ST_IDLE;
			end
			endcase
		end
	end

	// a pushed write reads the addressed register; for the memory data
	// register the port fetches from its own transfer address register
	always_ff @(posedge mclk) begin
		if (srst) begin
			apReq   <= 1'b0;
			apWrite <= 1'b0;
			apWdata <= '0;
		end else begin
			apReq   <= (state == PCVU_ST_ISSUE);
			apWrite <= curWrite && !pushed;
			apWdata <= pushed ? '0 : curData;
		end
	end

	// the reply to a read in a pushed mode is passed on as is; framing
	// completes normally even though its value is meaningless
	always_ff @(posedge mclk) begin
		if (srst) begin
			txnDone  <= 1'b0;
			txnRdata <= '0;
		end else begin
			txnDone <= (state == PCVU_ST_WAIT && apRsp
				&& !(pushed && curWrite)) || (state == PCVU_ST_CHECK
				&& cmpValid);
			if (state == PCVU_ST_WAIT && apRsp) begin
				txnRdata <= apRdata;
			end
		end
	end

	// ==========================================================
	// hold, compare, flag
	pcvu_hold_reg #(
		.DATA_W (DATA_W)
	) uHold (
		.mclk     (mclk),
		.srst     (srst),
		.load     (state == PCVU_ST_IDLE && txnValid && txnWrite
			&& isPushed(transfer_mode_field)),
		.loadData (txnData),
		.heldData (heldData)
	);

	pcvu_lane_cmp #(
		.LANES (LANES)
	) uCmp (
		.mclk     (mclk),
		.srst     (srst),
		.strobe   (state == PCVU_ST_WAIT && apRsp && pushed && curWrite),
		.a        (heldData),
		.b        (apRdata), // unsupported target: any data
		.laneMask (byte_lane_mask),
		.equal    (cmpEqual),
		.valid    (cmpValid)
	);

	assign setFlag = (state == PCVU_ST_CHECK) && cmpValid
		&& (((transfer_mode_field == PCVU_MODE_VERIFY) && cmpEqual)
		|| ((transfer_mode_field == PCVU_MODE_COMPARE)
		&& !cmpEqual));

	// set wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			compare_sticky_flag <= 1'b0;
		end else if (setFlag) begin
			compare_sticky_flag <= 1'b1;
		end else if (flagClr) begin
			compare_sticky_flag <= 1'b0;
		end
	end

	// decrement after a successful transaction that repeats; a same-cycle abort write stops a repeat from the wait state, not from check, and never the decrement
	always_ff @(posedge mclk) begin
		if (srst) begin
			repeat_counter <= '0;
		end else if (ctrlWr) begin
			repeat_counter <= avsWriteData[PCVU_CNT_LO +: CNT_W];
		end else if (((state == PCVU_ST_CHECK && cmpValid && !setFlag)
			|| (state == PCVU_ST_WAIT && apRsp && !(pushed && curWrite)))
			&& repeat_counter != '0 && !compare_sticky_flag) begin
			repeat_counter <= repeat_counter - 1'b1;
		end
	end

	// ==========================================================
	// interrupts
	assign seqDone = txnDone;

	always_ff @(posedge mclk) begin
		if (srst) begin
			irqStatus <= '0;
			irqEnable <= '0;
			irq       <= 1'b0;
		end else begin
			for (int i = 0; i < PCVU_EV_W; i++) begin
				if ((i == PCVU_EV_FLAG && setFlag)
					|| (i == PCVU_EV_DONE && seqDone)) begin
					irqStatus[i] <= 1'b1;
				end else if (irqClrWr && avsWriteData[i]) begin
					irqStatus[i] <= 1'b0;
				end
			end
			if (irqEnWr) begin
				irqEnable <= avsWriteData[PCVU_EV_W-1:0];
			end
			irq <= |(irqStatus & irqEnable);
		end
	end

	// ==========================================================
	// checks
	property p_flag_set;
		@(posedge mclk) disable iff (srst)
		setFlag |=> compare_sticky_flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("compare flag not set after hit");

	property p_clear;
		@(posedge mclk) disable iff (srst)
		flagClr && !setFlag |=> !compare_sticky_flag;
	endproperty
	a_clear: assert property (p_clear)
		else $error("compare flag not cleared by abort write");

	property p_no_write;
		@(posedge mclk) disable iff (srst)
		apReq && pushed && curWrite |-> !apWrite;
	endproperty
	a_no_write: assert property (p_no_write)
		else $error("pushed transaction wrote the port");

	property p_cnt_hold;
		@(posedge mclk) disable iff (srst)
		compare_sticky_flag && !ctrlWr |=> $stable(repeat_counter);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold)
		else $error("counter moved while flag set");

	property p_no_repeat;
		@(posedge mclk) disable iff (srst)
		setFlag |=> state == PCVU_ST_IDLE;
	endproperty
	a_no_repeat: assert property (p_no_repeat)
		else $error("repeat continued after compare hit");

	property p_normal;
		@(posedge mclk) disable iff (srst)
		transfer_mode_field == PCVU_MODE_NORMAL && !flagClr
		|=> $stable(compare_sticky_flag) || $past(setFlag);
	endproperty
	a_normal: assert property (p_normal)
		else $error("flag changed in normal mode");

	property p_hold;
		@(posedge mclk) disable iff (srst)
		state != PCVU_ST_IDLE |=> $stable(heldData);
	endproperty
	a_hold: assert property (p_hold)
		else $error("held value changed mid comparison");

	property p_verify;
		@(posedge mclk) disable iff (srst)
		state == PCVU_ST_CHECK && cmpValid && cmpEqual
		&& transfer_mode_field == PCVU_MODE_VERIFY |=> compare_sticky_flag;
	endproperty
	a_verify: assert property (p_verify)
		else $error("verify match did not set flag");

	property p_cmp_match;
		@(posedge mclk) disable iff (srst)
		state == PCVU_ST_CHECK && cmpValid && cmpEqual
		&& transfer_mode_field == PCVU_MODE_COMPARE && !flagClr
		|=> $stable(compare_sticky_flag);
	endproperty
	a_cmp_match: assert property (p_cmp_match)
		else $error("compare match changed flag");

endmodule
`default_nettype wire

// ---- test/pcvu_ap_model.sv ----
/*
 * access port model: a memory port whose transfer address steps after
 * each access; answers each request once, promptly or after a stall.
 * assumes requests are one-cycle pulses that never overlap.
 */
`timescale 1ns/1ps
`default_nettype none
module pcvu_ap_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// request side
	input  wire logic        apReq,
	input  wire logic        apWrite,
	input  wire logic [31:0] apWdata,
	// answer side
	output logic             apRsp,
	output logic      [31:0] apRdata,
	// bench controls
	input  wire logic        slow,
	input  wire logic        rewind
);
	// ==========================================================
	// state
	logic [31:0] mem [8];
	logic [2:0]  transfer_address_reg;
	logic [3:0]  stall;
	logic        pend;
	logic        isWr;
	logic [31:0] wd;

	// ==========================================================
	// answer logic
	always @(posedge mclk) begin
		apRsp <= 1'b0;
		if (srst) begin
			pend    <= 1'b0;
			transfer_address_reg     <= 3'h0;
			apRdata <= 32'h0;
			for (int i = 0; i < 8; i++)
				mem[i] <= 32'h5a000000 + 32'(i);
		end else begin
			if (rewind)
				transfer_address_reg <= 3'h0;
			if (apReq) begin
				pend  <= 1'b1;
				stall <= slow ? 4'h5 : 4'h0;
				isWr  <= apWrite;
				wd    <= apWdata;
			end else if (pend && stall != 4'h0) begin
				stall <= stall - 4'h1;
			end else if (pend) begin
				// access memory at the transfer address, then step it
				pend    <= 1'b0;
				apRsp   <= 1'b1;
				apRdata <= isWr ? 32'h0 : mem[transfer_address_reg];
				transfer_address_reg     <= transfer_address_reg + 3'h1;
				if (isWr)
					mem[transfer_address_reg] <= wd;
			end else begin
				// released bus: never leave the last value standing
				apRdata <= ~apRdata;
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/pcvu_core_tb_top.sv ----
/*
 * self-checking bench of the pushed compare/verify core.
 * assumes the access port model beside it; one clock at 250 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
module pcvu_core_tb_top;
	import pcvu_pkg::*;
	// ==========================================================
	// signals
	logic        mclk, srst, avsRead, avsWrite, avsWaitRequest, irq;
	logic        txnValid, txnWrite, txnDone, apReq, apWrite, apRsp;
	logic        slow, rewind;
	logic [4:0]  avsAddress;
	logic [31:0] avsWriteData, avsReadData, txnData, txnRdata;
	logic [31:0] apWdata, apRdata, lastWd = 32'h0;
	int          failures, n_tests, n0;
	int          nReq = 0, nWr = 0, nDone = 0;
	localparam logic [4:0] A_CTRL = {1'b0, PCVU_ADDR_CTRL};
	localparam logic [4:0] A_STAT = {1'b0, PCVU_ADDR_STAT};
	localparam logic [4:0] A_IRQS = {1'b0, PCVU_ADDR_IRQST};
	localparam logic [4:0] A_IEN  = {1'b1, PCVU_ADDR_IRQEN};

	pcvu_core i_dut (.mclk(mclk), .srst(srst), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
		.txnValid(txnValid), .txnWrite(txnWrite), .txnData(txnData),
		.txnDone(txnDone), .txnRdata(txnRdata), .apReq(apReq),
		.apWrite(apWrite), .apWdata(apWdata), .apRsp(apRsp),
		.apRdata(apRdata), .irq(irq));
	pcvu_ap_model i_ap (.mclk(mclk), .srst(srst), .apReq(apReq),
		.apWrite(apWrite), .apWdata(apWdata), .apRsp(apRsp),
		.apRdata(apRdata), .slow(slow), .rewind(rewind));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// port activity seen by the bench
	always @(posedge mclk) begin
		if (txnDone === 1'b1)
			nDone <= nDone + 1;
		if (apReq === 1'b1) begin
			nReq <= nReq + 1;
			if (apWrite === 1'b1) begin
				nWr    <= nWr + 1;
				lastWd <= apWdata;
			end
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [4:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge mclk);
		avsAddress   <= a;
		avsWriteData <= wd;
		avsWrite     <= we;
		avsRead      <= !we;
		// hold the request until the edge that samples waitrequest low
		do begin
			@(posedge mclk);
			n++;
		end while (avsWaitRequest !== 1'b0 && n < 100);
		if (n >= 100)
			failures++;
		rd = avsReadData;
		avsWrite <= 1'b0;
		avsRead  <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		chk(v, e);
	endtask

	task automatic setc(input logic [1:0] m, input logic [3:0] k,
		input logic [11:0] c);
		wr(A_CTRL, {8'h0, c, k, 6'h0, m});
	endtask

	task automatic txn(input logic w, input logic [31:0] d);
		@(posedge mclk);
		txnValid <= 1'b1;
		txnWrite <= w;
		txnData  <= d;
		@(posedge mclk);
		txnValid <= 1'b0;
	endtask

	task automatic idle();
		logic [31:0] v;
		int n;
		n = 0;
		do begin
			bus(1'b0, A_STAT, 32'h0, v);
			n++;
		end while (v[PCVU_ST_BUSY] !== 1'b0 && n < 50);
		if (n >= 50)
			failures++;
	endtask

	task automatic restart();
		wr({1'b0, PCVU_ADDR_ABORT}, 32'h2);
		@(posedge mclk);
		rewind <= 1'b1;
		@(posedge mclk);
		rewind <= 1'b0;
	endtask

	task automatic give_verdict();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		rchk(A_CTRL, 32'h00000f00);
		rchk(A_STAT, 32'h0);
		rchk(5'h18, 32'h0);
	endtask

	task automatic t_verify();
		restart();
		setc(2'h1, 4'h5, 12'h0);
		n0 = nWr;
		txn(1'b1, 32'h5aff0000); // pushed write: the port is read, never written
		idle();
		rchk(A_STAT, 32'h0);
		txn(1'b1, 32'h12001201);
		idle();
		rchk(A_STAT, 32'h1);
		chk(32'(nWr - n0), 32'h0);
		restart();
		rchk(A_STAT, 32'h0);
	endtask

	task automatic t_compare();
		wr(A_IEN, 32'h1);
		setc(2'h2, 4'hf, 12'h0);
		txn(1'b1, 32'h5a000000);
		idle();
		rchk(A_STAT, 32'h0);
		txn(1'b1, 32'h5a000000);
		idle();
		rchk(A_STAT, 32'h1);
		rchk(A_IRQS, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(A_IEN, 32'h0);
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		wr({1'b1, PCVU_ADDR_IRQCLR}, 32'h3);
		wr(A_IEN, 32'h3);
		rchk(A_IRQS, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_repeat();
		restart();
		setc(2'h1, 4'hf, 12'h3);
		n0 = nReq;
		txn(1'b1, 32'h5a000002);
		idle();
		chk(32'(nReq - n0), 32'h3);
		rchk(A_STAT, 32'h11);
		n0 = nReq;
		txn(1'b1, 32'h5a000002);
		idle();
		rchk(A_STAT, 32'h11);
		chk({31'h0, (nReq - n0) <= 1}, 32'h1);
	endtask

	task automatic t_busy();
		restart();
		slow <= 1'b1;
		setc(2'h1, 4'hf, 12'h0);
		n0 = nReq;
		txn(1'b1, 32'h5a000000);
		txn(1'b1, 32'h0);
		idle();
		chk(32'(nReq - n0), 32'h1);
		rchk(A_STAT, 32'h1);
		slow <= 1'b0;
	endtask

	task automatic t_pushread();
		restart();
		setc(2'h2, 4'hf, 12'h0);
		n0 = nDone;
		txn(1'b0, 32'h0);
		idle();
		chk(32'(nDone - n0), 32'h1);
	endtask

	task automatic t_normal();
		restart();
		setc(2'h0, 4'hf, 12'h0);
		n0 = nWr;
		txn(1'b1, 32'hcafe0001);
		idle();
		chk(32'(nWr - n0), 32'h1);
		chk(lastWd, 32'hcafe0001);
		rchk(A_STAT, 32'h0);
		txn(1'b0, 32'h0);
		idle();
		chk(txnRdata, 32'h5a000001);
		// the reserved mode code behaves as normal transfers
		setc(2'h3, 4'hf, 12'h0);
		txn(1'b1, 32'hcafe0002);
		idle();
		chk(lastWd, 32'hcafe0002);
		rchk(A_STAT, 32'h0);
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		{srst, avsRead, avsWrite, txnValid, txnWrite, slow, rewind} = 7'h40;
		{avsAddress, avsWriteData, txnData} = '0;
		{failures, n_tests} = '0;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_verify();
		t_compare();
		t_repeat();
		t_busy();
		t_pushread();
		t_normal();
		give_verdict();
	end

	initial begin
		#100000;
		failures++;
		give_verdict();
	end
endmodule
`default_nettype wire
